// >>> ifm_pkg.sv
// Constants and carrier types for the interpolating filter mode control
package ifm_pkg;
   // ------------------------------------------------------------
   // Data word
   // ------------------------------------------------------------
   localparam logic [15:0] MID_SCALE  = 16'h8000; // Output clear code
   localparam logic [4:0]  FRAME_CLKS = 5'h10;    // Edges per frame
   localparam logic [4:0]  FCNT_MAX   = 5'h1f;    // Count saturates
   localparam logic [3:0]  STEP_MASK  = 4'h7;     // Step mask at ratio 2
   localparam logic [1:0]  K_SHIFT    = 2'h3;     // Phase shift at ratio 2
   localparam logic [4:0]  N_BASE     = 5'h02;    // Lowest ratio
   localparam logic [4:0]  SH_BASE    = 5'h03;    // Divide by 2*N*N

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL   = 4'h0;  // Control
   localparam logic [3:0]  REG_LATCH  = 4'h4;  // Output latch
   localparam logic [3:0]  REG_STAT   = 4'h8;  // Status
   localparam int unsigned CTRL_AUTO  = 0;     // Auto reset enable
   localparam logic        CTRL_RST   = 1'b1;  // Auto reset on
   localparam int unsigned STAT_RUN   = 0;     // Filter running
   localparam int unsigned STAT_RATIO = 1;     // Ratio code, 2 bits
   localparam int unsigned STAT_ERR   = 8;     // Bad frames, 8 bits

   // ------------------------------------------------------------
   // Carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic filter_use_n_bypass;
      logic filter_reset_n;
      logic ratio_sel_hi;
      logic ratio_sel_lo;
      logic output_mute_n;
   } cfg_s;

   typedef struct packed {
      logic bit_clk;
      logic frame_sync;
      logic serial_word_in;
   } link_s;

   typedef enum logic [1:0] {FILT_HALT, FILT_ARM, FILT_RUN} filt_e;
endpackage

// >>> interp_filter_mode_control.sv
// Mode control, serial input and quadratic interpolator of the output path
`timescale 1ns/10ps
`default_nettype none
module interp_filter_mode_control
   import ifm_pkg::*;
(
   input  wire logic        SYS_CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        BIT_CLK_I,
   input  wire logic        FRAME_SYNC_I,
   input  wire logic        SERIAL_WORD_IN_I,
   input  wire logic        FILTER_USE_N_BYPASS_I,
   input  wire logic        FILTER_RESET_N_I,
   input  wire logic        RATIO_SEL_HI_I,
   input  wire logic        RATIO_SEL_LO_I,
   input  wire logic        OUTPUT_MUTE_N_I,
   input  wire logic [3:0]  ADR_I,
   input  wire logic [31:0] DAT_I,
   input  wire logic        WE_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic        STB_I,
   input  wire logic        CYC_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   output logic      [15:0] LATCH_O,
   output logic             UPDATE_O,
   output logic             FILTER_RUN_O
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   cfg_s  cfg_m;   // First stage, read by second only
   cfg_s  cfg;     // Config pins, safe to use
   link_s lnk_m;   // First stage, read by second only
   link_s lnk;     // Link pins, safe to use
   logic  clk_d;   // Bit clock one cycle back

   // Two flops on every asynchronous pin
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         cfg_m <= '0;
         cfg   <= '0;
         lnk_m <= '0;
         lnk   <= '0;
         clk_d <= 1'b0;
      end else begin
         cfg_m <= {FILTER_USE_N_BYPASS_I, FILTER_RESET_N_I,
                   RATIO_SEL_HI_I, RATIO_SEL_LO_I, OUTPUT_MUTE_N_I};
         cfg   <= cfg_m;
         lnk_m <= {BIT_CLK_I, FRAME_SYNC_I, SERIAL_WORD_IN_I};
         lnk   <= lnk_m;
         clk_d <= lnk.bit_clk;
      end
   end

   // ------------------------------------------------------------
   // Decoded pin levels
   // ------------------------------------------------------------
   logic       rise;     // Rising bit clock edge
   logic       use_flt;  // Latch fed by filter
   logic       mute;     // Output clear wanted
   logic [1:0] code;     // Ratio code
   logic [3:0] mask;     // Step spacing minus one
   logic [1:0] kshift;   // Counter to phase shift

   assign rise    = lnk.bit_clk & ~clk_d;
   assign use_flt = cfg.filter_use_n_bypass;
   assign mute    = ~cfg.output_mute_n;
   assign code    = {cfg.ratio_sel_hi, cfg.ratio_sel_lo};
   assign mask    = STEP_MASK >> code;
   assign kshift  = K_SHIFT - code;

   // ------------------------------------------------------------
   // Quadratic interpolation between three words
   // ------------------------------------------------------------
   // Weights (N-k)^2, 2N^2-(N-k)^2-k^2, k^2 over 2N^2; N is a
   // power of two so the divide is a shift and never rounds badly
   function automatic logic [15:0] interp(
      input logic [15:0] a0,
      input logic [15:0] a1,
      input logic [15:0] a2,
      input logic [3:0]  k,
      input logic [1:0]  c
   );
      logic [4:0]  n;
      logic [4:0]  nk;
      logic [9:0]  wa;
      logic [9:0]  wb;
      logic [9:0]  wc;
      logic [26:0] acc;
      logic [4:0]  sh;
      n   = N_BASE << c;
      nk  = n - {1'b0, k};
      wa  = {5'h00, nk} * {5'h00, nk};
      wc  = {6'h00, k} * {6'h00, k};
      wb  = (({5'h00, n} * {5'h00, n}) << 1) - wa - wc;
      acc = {17'h0, wa} * {11'h0, a0}
          + {17'h0, wb} * {11'h0, a1}
          + {17'h0, wc} * {11'h0, a2};
      sh  = {2'b00, c, 1'b0} + SH_BASE;
      return 16'(acc >> sh);
   endfunction

   // ------------------------------------------------------------
   // Serial input, filter and output latch
   // ------------------------------------------------------------
   logic [15:0] sreg;      // Input shift register
   logic [15:0] temp;      // Temporary word register
   logic        fs_d;      // Frame sync at last edge
   logic        fs_fell;   // Frame fell at last edge
   logic [4:0]  fcnt;      // Edges in current frame
   logic [3:0]  cnt;       // Edges since word entered filter
   logic [15:0] p0;        // Oldest filter input
   logic [15:0] p1;        // Previous filter input
   logic [15:0] p2;        // Current filter input
   filt_e       fstate;    // Filter run state
   logic [15:0] latch;     // Output latch
   logic        upd;       // Latch loaded pulse
   logic [7:0]  err;       // Bad frames seen
   logic [15:0] next_sreg;
   logic [15:0] next_temp;
   logic        next_fs_d;
   logic        next_fs_fell;
   logic [4:0]  next_fcnt;
   logic [3:0]  next_cnt;
   logic [15:0] next_p0;
   logic [15:0] next_p1;
   logic [15:0] next_p2;
   filt_e       next_fstate;
   logic [15:0] next_latch;
   logic        next_upd;
   logic [7:0]  next_err;
   logic        auto_en;   // Auto reset enable bit
   logic        fs_fall;   // Frame falls at this edge
   logic        step;      // Filter output step
   logic [15:0] y;         // Filter output word

   assign fs_fall = rise & fs_d & ~lnk.frame_sync;

   // Next values of the datapath
   always_comb begin
      next_sreg    = sreg;
      next_temp    = temp;
      next_fs_d    = fs_d;
      next_fs_fell = fs_fell;
      next_fcnt    = fcnt;
      next_cnt     = cnt;
      next_p0      = p0;
      next_p1      = p1;
      next_p2      = p2;
      next_fstate  = fstate;
      next_latch   = latch;
      next_upd     = 1'b0;
      next_err     = err;
      step         = 1'b0;
      // Release waits for a word boundary to restart
      if (fstate == FILT_HALT) begin
         next_fstate = FILT_ARM;
      end
      if (rise) begin
         // Input path never stops, muted or reset
         next_sreg    = {sreg[14:0], lnk.serial_word_in};
         next_fs_d    = lnk.frame_sync;
         next_fs_fell = fs_fall;
         next_fcnt    = (fcnt == FCNT_MAX) ? fcnt : fcnt + 5'h01;
         if (fstate == FILT_RUN) begin
            next_cnt = cnt + 4'h1;
            step = ((next_cnt & mask) == 4'h0) && (next_cnt != 4'h0);
         end
         if (fs_fall) begin
            // Last 16 bits before the fall, right-justified
            next_temp = sreg;
            next_fcnt = 5'h01;
            if (fstate == FILT_RUN && fcnt != FRAME_CLKS) begin
               next_err = (err == 8'hff) ? err : err + 8'h01;
               if (auto_en) begin
                  next_fstate = FILT_ARM;
               end
            end
         end
         if (fs_fell && fstate != FILT_HALT && next_fstate != FILT_HALT) begin
            // Second edge after the fall: word enters filter
            next_fstate = FILT_RUN;
            next_cnt    = 4'h0;
            step        = 1'b1;
            next_p0     = p1;
            next_p1     = p2;
            next_p2     = temp;
         end
      end
      // Low reset pin halts only the filter
      if (!cfg.filter_reset_n) begin
         next_fstate = FILT_HALT;
         next_cnt    = 4'h0;
      end
      // Cleared history reads as mid-scale
      if (next_fstate != FILT_RUN) begin
         next_p0 = MID_SCALE;
         next_p1 = MID_SCALE;
         next_p2 = MID_SCALE;
      end
      y = interp(next_p0, next_p1, next_p2, next_cnt >> kshift, code);
      // Output latch selection at each scheduled update
      if (rise && fs_fell) begin
         next_upd = 1'b1;
         if (mute) begin
            next_latch = MID_SCALE;
         end else if (!use_flt) begin
            next_latch = temp;
         end else if (next_fstate == FILT_RUN) begin
            next_latch = y;
         end else begin
            next_latch = MID_SCALE;
         end
      end else if (rise && use_flt && !cfg.filter_reset_n) begin
         // Only visible while bit clock runs and filter in use
         next_upd   = 1'b1;
         next_latch = MID_SCALE;
      end else if (rise && use_flt && step) begin
         next_upd   = 1'b1;
         next_latch = mute ? MID_SCALE : y;
      end
   end

   // Datapath registers
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         sreg    <= 16'h0000;
         temp    <= MID_SCALE;
         fs_d    <= 1'b0;
         fs_fell <= 1'b0;
         fcnt    <= 5'h00;
         cnt     <= 4'h0;
         p0      <= MID_SCALE;
         p1      <= MID_SCALE;
         p2      <= MID_SCALE;
         fstate  <= FILT_HALT;
         latch   <= MID_SCALE;
         upd     <= 1'b0;
         err     <= 8'h00;
      end else begin
         sreg    <= next_sreg;
         temp    <= next_temp;
         fs_d    <= next_fs_d;
         fs_fell <= next_fs_fell;
         fcnt    <= next_fcnt;
         cnt     <= next_cnt;
         p0      <= next_p0;
         p1      <= next_p1;
         p2      <= next_p2;
         fstate  <= next_fstate;
         latch   <= next_latch;
         upd     <= next_upd;
         err     <= next_err;
      end
   end

   // ------------------------------------------------------------
   // Wishbone classic slave
   // ------------------------------------------------------------
   logic        ack;          // Bus acknowledge
   logic [31:0] rdat;         // Read data register
   logic        next_ack;
   logic [31:0] next_rdat;
   logic        next_auto_en;
   logic        req;          // New access this cycle

   // One wait state; unmapped reads give zero and still ack
   always_comb begin
      req          = CYC_I & STB_I & ~ack;
      next_ack     = req;
      next_rdat    = 32'h0000_0000;
      next_auto_en = auto_en;
      // Write commits at the edge where the master samples ack
      if (ack && CYC_I && STB_I && WE_I && ADR_I == REG_CTRL && SEL_I[0]) begin
         next_auto_en = DAT_I[CTRL_AUTO];
      end
      if (req && !WE_I) begin
         unique case (ADR_I)
            REG_CTRL: begin
               next_rdat[CTRL_AUTO] = auto_en;
            end
            REG_LATCH: begin
               next_rdat[15:0] = latch;
            end
            REG_STAT: begin
               next_rdat[STAT_RUN]       = (fstate == FILT_RUN);
               next_rdat[STAT_RATIO +: 2] = code;
               next_rdat[STAT_ERR +: 8]   = err;
            end
            default: begin
               next_rdat = 32'h0000_0000;
            end
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         ack     <= 1'b0;
         rdat    <= 32'h0000_0000;
         auto_en <= CTRL_RST;
      end else begin
         ack     <= next_ack;
         rdat    <= next_rdat;
         auto_en <= next_auto_en;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flops
   // ------------------------------------------------------------
   logic run_q;  // Filter running flag

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         run_q <= 1'b0;
      end else begin
         run_q <= (next_fstate == FILT_RUN);
      end
   end

   assign DAT_O        = rdat;
   assign ACK_O        = ack;
   assign LATCH_O      = latch;
   assign UPDATE_O     = upd;
   assign FILTER_RUN_O = run_q;

endmodule
`default_nettype wire

// >>> ifm_asserts.sv
// Port-level checks for the filter mode control
`timescale 1ns/10ps
`default_nettype none
module ifm_asserts
   import ifm_pkg::*;
(
   input wire logic        SYS_CLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        FILTER_USE_N_BYPASS_I,
   input wire logic        FILTER_RESET_N_I,
   input wire logic        RATIO_SEL_HI_I,
   input wire logic        RATIO_SEL_LO_I,
   input wire logic        OUTPUT_MUTE_N_I,
   input wire logic [3:0]  ADR_I,
   input wire logic        WE_I,
   input wire logic        STB_I,
   input wire logic        CYC_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   input wire logic [15:0] LATCH_O,
   input wire logic        UPDATE_O,
   input wire logic        FILTER_RUN_O
);
   // ------
   // Checks
   // ------
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   property p_ack_next;
      CYC_I && STB_I && !ACK_O |=> ACK_O;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus not answered");
   property p_ack_once;
      ACK_O |=> !ACK_O;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held too long");
   property p_ratio_stat;
      ACK_O && !WE_I && ADR_I == REG_STAT |-> DAT_O[2:1] == {RATIO_SEL_HI_I, RATIO_SEL_LO_I};
   endproperty
   a_ratio_stat: assert property (p_ratio_stat) else $error("ratio code wrong");
   // Settled mute forces mid-scale at any load
   property p_mute_mid;
      (!OUTPUT_MUTE_N_I) [*6] ##0 UPDATE_O |-> LATCH_O == MID_SCALE;
   endproperty
   a_mute_mid: assert property (p_mute_mid) else $error("mute ignored");
   property p_init_mid;
      (FILTER_USE_N_BYPASS_I && !FILTER_RESET_N_I) [*8] ##0 UPDATE_O |-> LATCH_O == MID_SCALE;
   endproperty
   a_init_mid: assert property (p_init_mid) else $error("init not mid");
   property p_halt;
      (!FILTER_RESET_N_I) [*8] |-> !FILTER_RUN_O;
   endproperty
   a_halt: assert property (p_halt) else $error("filter not halted");
   // Latch loads are at least six cycles apart
   property p_upd_gap;
      UPDATE_O |=> !UPDATE_O [*5];
   endproperty
   a_upd_gap: assert property (p_upd_gap) else $error("loads too close");
   property p_latch_src;
      $changed(LATCH_O) |-> UPDATE_O;
   endproperty
   a_latch_src: assert property (p_latch_src) else $error("latch moved alone");
endmodule
bind interp_filter_mode_control ifm_asserts u_ifm_asserts (
   .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .FILTER_RESET_N_I(FILTER_RESET_N_I),
   .FILTER_USE_N_BYPASS_I(FILTER_USE_N_BYPASS_I), .RATIO_SEL_HI_I(RATIO_SEL_HI_I),
   .RATIO_SEL_LO_I(RATIO_SEL_LO_I), .OUTPUT_MUTE_N_I(OUTPUT_MUTE_N_I), .ADR_I(ADR_I),
   .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .LATCH_O(LATCH_O), .UPDATE_O(UPDATE_O), .FILTER_RUN_O(FILTER_RUN_O));
`default_nettype wire

// >>> ctl_model.sv
// Controller model: bit clock, frame sync and serial data
`timescale 1ns/10ps
`default_nettype none
module ctl_model
   import ifm_pkg::*;
(
   input  wire logic clk_i,
   output var link_s link_o
);
   initial link_o = '0;
   // 800 ns bit clock keeps any ratio far below the update limit
   task automatic bit_out(input logic d, input logic fs);
      link_o.bit_clk <= 1'b0;
      link_o.serial_word_in <= d;
      link_o.frame_sync <= fs;
      repeat (4) @(posedge clk_i);
      link_o.bit_clk <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
   // MSB first, sync high on the last bit; n other than 16 is a bad frame
   task automatic send(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         bit_out((i > 15) ? 1'b0 : v[i], i == 0);
      end
      @(posedge clk_i);
      link_o.serial_word_in <= ~link_o.serial_word_in; // No stale bit when idle
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Bench for the filter mode control: bus, link and mode scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import ifm_pkg::*;
;
   logic        clk, rst, we, stb, cyc, ack, upd, run;
   cfg_s        cfg;
   link_s       link;
   logic [3:0]  adr, sel;
   logic [31:0] dat_w, dat_r, q;
   logic [15:0] latch, w;
   int          err_total, n_tests, upd_cnt, cycles;
   interp_filter_mode_control u_interp_filter_mode_control (
      .SYS_CLK_I(clk), .SYS_RST_I(rst), .BIT_CLK_I(link.bit_clk),
      .FRAME_SYNC_I(link.frame_sync), .SERIAL_WORD_IN_I(link.serial_word_in),
      .FILTER_USE_N_BYPASS_I(cfg.filter_use_n_bypass), .FILTER_RESET_N_I(cfg.filter_reset_n),
      .RATIO_SEL_HI_I(cfg.ratio_sel_hi), .RATIO_SEL_LO_I(cfg.ratio_sel_lo),
      .OUTPUT_MUTE_N_I(cfg.output_mute_n), .ADR_I(adr), .DAT_I(dat_w), .WE_I(we),
      .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_r), .ACK_O(ack),
      .LATCH_O(latch), .UPDATE_O(upd), .FILTER_RUN_O(run));
   ctl_model u_ctl_model (.clk_i(clk), .link_o(link));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Count latch loads; cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (upd === 1'b1) upd_cnt++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle, held until ack
   task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= wr;
      dat_w <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      cfg = 5'h00;
      {we, stb, cyc, adr, dat_w} = '0;
      sel = 4'hf;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(REG_CTRL, 1'b0, 32'h0);
      chk(q, 32'h1);
      bus(4'hc, 1'b0, 32'h0);
      chk(q, 32'h0);
      bus(REG_LATCH, 1'b1, 32'h1234);
      bus(REG_LATCH, 1'b0, 32'h0);
      chk(q, {16'h0, MID_SCALE});
      bus(REG_CTRL, 1'b1, 32'h0);
      bus(REG_CTRL, 1'b0, 32'h0);
      chk(q, 32'h0);
      bus(REG_CTRL, 1'b1, 32'h1);
      $display("test registers done");
      cfg <= 5'h01;
      u_ctl_model.send(16'h1234, 16);
      u_ctl_model.send(16'ha5c3, 17);
      chk(latch, 16'h1234);
      u_ctl_model.send(16'h0f0f, 16);
      chk(latch, 16'ha5c3);
      cfg <= 5'h00;
      u_ctl_model.send(16'h7777, 16);
      chk(latch, MID_SCALE);
      cfg <= 5'h01;
      u_ctl_model.send(16'h2222, 16);
      chk(latch, 16'h7777);
      cfg <= 5'h11;
      u_ctl_model.send(16'h4321, 16);
      chk(latch, MID_SCALE);
      bus(REG_STAT, 1'b0, 32'h0);
      chk(q & 32'h1, 32'h0);
      $display("test modes done");
      for (int c = 0; c < 4; c++) begin
         w = {14'h0c00, c[1:0]};
         cfg <= {1'b1, 1'b0, c[1:0], 1'b1};
         u_ctl_model.send(w, 16);
         cfg.filter_reset_n <= 1'b1;
         repeat (6) u_ctl_model.send(w, 16);
         repeat (8) @(posedge clk);
         upd_cnt = 0;
         u_ctl_model.send(w, 16);
         repeat (8) @(posedge clk);
         chk(upd_cnt, 32'h2 << c);
         chk(latch, w);
      end
      $display("test ratios done");
      bus(REG_STAT, 1'b0, 32'h0);
      chk(q[15:0], 16'h0007);
      u_ctl_model.send(w, 15);
      repeat (2) u_ctl_model.send(w, 16);
      bus(REG_STAT, 1'b0, 32'h0);
      chk(q[15:8], 8'h01);
      cfg <= 5'h0f;
      repeat (2) u_ctl_model.send(16'h5555, 16);
      chk(latch, 16'h5555);
      chk(run, 1'b1);
      cfg <= 5'h1f;
      repeat (2) u_ctl_model.send(16'h5555, 16);
      chk(latch, 16'h5555);
      repeat (2) u_ctl_model.send(16'h5755, 16);
      chk(latch, 16'h5619);
      $display("test frames done");
      summarize();
   end
endmodule
`default_nettype wire
